// ==== rtl/ddl_pkg.sv ====
// Purpose: shared constants and types of the decimating column loader
// Assumes: one 40 MHz system clock, Wishbone register access
// Notes: pixel clock and pins arrive asynchronously and are resynchronised

package ddl_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int DDL_NUM_CH = 6;
  localparam int DDL_CODE_W = 10;
  localparam int DDL_PTR_W = 3;
  localparam int DDL_SYNC_STAGES = 2;
  localparam logic [9:0] DDL_FULL_SCALE = 10'h3ff;
  localparam logic [2:0] DDL_CH_LEFT = 3'h0;
  localparam logic [2:0] DDL_CH_RIGHT = 3'h5;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int DDL_ADR_W = 8;
  localparam logic [7:0] DDL_OFS_CTRL = 8'h00;
  localparam logic [7:0] DDL_OFS_STATUS = 8'h04;
  localparam logic [7:0] DDL_OFS_LATCH0 = 8'h10;
  localparam logic [7:0] DDL_OFS_OUT0 = 8'h30;

  // Control fields
  localparam int DDL_CTRL_EDGE_BIT = 0;
  localparam int DDL_CTRL_DIR_BIT = 1;
  localparam int DDL_CTRL_POL_BIT = 2;
  localparam int DDL_CTRL_HOLD_BIT = 3;
  localparam logic [3:0] DDL_CTRL_RST = 4'h1;

  // Status fields
  localparam int DDL_STAT_FRESH_LSB = 0;
  localparam int DDL_STAT_LOAD_BIT = 8;
  localparam int DDL_STAT_START_BIT = 9;
  localparam int DDL_STAT_XFER_BIT = 10;
  localparam int DDL_STAT_PTR_LSB = 12;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lp_hold;
    logic pol_inv;
    logic dir_sel;
    logic edge_sel;
  } ddl_ctrl_t;

  typedef struct packed {
    logic pix_clk;
    logic [DDL_CODE_W-1:0] code;
    logic start;
    logic xfer;
  } ddl_pins_t;

  typedef enum logic {DDL_IDLE, DDL_LOAD} ddl_seq_t;

endpackage

// ==== rtl/ddl_sync.sv ====
// Purpose: two-stage resynchroniser for a bundle of asynchronous pins
// Assumes: each bit is a level, no bus coherency across bits needed
// Notes: stage one feeds stage two only

module ddl_sync
  import ddl_pkg::*;
#(
  parameter int W = 1
)
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  if (W < 1)
  begin : g_bad_w
    $error("ddl_sync: W must be at least 1");
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// ==== rtl/ddl_col_conv.sv ====
// Purpose: digital transfer function of one column channel
// Assumes: code is stable between output transfers
// Notes: magnitude is full scale minus code, sign from polarity

module ddl_col_conv
  import ddl_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic pol_inv_i,
  input wire logic lp_hold_i,
  // Channel
  input wire logic [DDL_CODE_W-1:0] code_i,
  output logic [DDL_CODE_W-1:0] level_o,
  output logic above_mid_o
);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || lp_hold_i)
    begin
      // Debiased: no drive away from the white reference
      level_o <= '0;
      above_mid_o <= 1'b0;
    end
    else
    begin
      level_o <= DDL_FULL_SCALE - code_i;
      above_mid_o <= pol_inv_i;
    end
  end

endmodule

// ==== rtl/ddl_loader.sv ====
// Purpose: input-side control of a six-channel decimating column driver
// Assumes: pixel clock at most a quarter of clk_i, pins held 3+ cycles
// Notes: pin levels are sampled just before each detected pixel edge
//
// Added by the designer: the Wishbone register port and the register offsets.

module ddl_loader
  import ddl_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DDL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timing controller pins
  input wire logic pixel_clock_i,
  input wire logic [DDL_CODE_W-1:0] pixel_code_input_i,
  input wire logic sequence_start_strobe_i,
  input wire logic output_transfer_strobe_i,
  // Column outputs
  output logic [DDL_NUM_CH-1:0][DDL_CODE_W-1:0] column_voltage_outputs_o,
  output logic [DDL_NUM_CH-1:0] column_above_mid_o,
  output logic column_bias_en_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ddl_pins_t pins_raw;
  ddl_pins_t pins_s;
  ddl_pins_t pins_prev_r;
  ddl_ctrl_t ctrl_r;
  ddl_seq_t seq_r;
  logic [DDL_PTR_W-1:0] ptr_r;
  logic [DDL_PTR_W-1:0] ptr_nxt;
  logic [DDL_PTR_W-1:0] cnt_r;
  logic [DDL_PTR_W-1:0] first_ch;
  logic start_armed_r;
  logic xfer_seen_r;
  logic [DDL_NUM_CH-1:0] fresh_r;
  logic [DDL_CODE_W-1:0] latch_r [DDL_NUM_CH];
  logic [DDL_CODE_W-1:0] out_r [DDL_NUM_CH];
  logic pix_rise;
  logic pix_fall;
  logic act_edge;
  logic load_en;
  logic [DDL_PTR_W-1:0] load_ch;
  logic wb_req;
  logic [31:0] rd_data;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The pointer must reach every channel and the far end must be the
  // last channel, or the fill walk would skip or overrun a latch.
  if (DDL_NUM_CH > (1 << DDL_PTR_W) || DDL_CH_RIGHT != DDL_NUM_CH - 1)
  begin : g_chk
    $error("ddl_loader: channel count does not fit the pointer width");
  end

  // ----------------------------------------------------------------
  // Pin resynchronisation
  // ----------------------------------------------------------------
  assign pins_raw.pix_clk = pixel_clock_i;
  assign pins_raw.code = pixel_code_input_i;
  assign pins_raw.start = sequence_start_strobe_i;
  assign pins_raw.xfer = output_transfer_strobe_i;

  ddl_sync #(
    .W($bits(ddl_pins_t))
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  // One more stage gives the pin levels as they stood before an edge,
  // which is what the controller set up for that edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pins_prev_r <= '0;
    else
      pins_prev_r <= pins_s;
  end

  // ----------------------------------------------------------------
  // Pixel clock edge detection
  // ----------------------------------------------------------------
  assign pix_rise = pins_s.pix_clk & ~pins_prev_r.pix_clk;
  assign pix_fall = ~pins_s.pix_clk & pins_prev_r.pix_clk;
  assign act_edge = ctrl_r.edge_sel ? pix_rise : pix_fall;

  // ----------------------------------------------------------------
  // Load sequencing
  // ----------------------------------------------------------------
  assign first_ch = ctrl_r.dir_sel ? DDL_CH_RIGHT : DDL_CH_LEFT;
  assign load_en = act_edge & (start_armed_r | (seq_r == DDL_LOAD));
  assign load_ch = start_armed_r ? first_ch : ptr_r;

  always_comb
  begin
    // Step away from the end the sequence started at
    if (ctrl_r.dir_sel)
      ptr_nxt = load_ch - 3'h1;
    else
      ptr_nxt = load_ch + 3'h1;
  end

  // Start strobe arms on one active edge, the sequence opens on the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_armed_r <= 1'b0;
    else if (act_edge)
      start_armed_r <= pins_prev_r.start;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_r <= DDL_IDLE;
      ptr_r <= '0;
      cnt_r <= '0;
    end
    else if (load_en)
    begin
      ptr_r <= ptr_nxt;
      if (start_armed_r)
      begin
        // A fresh start restarts even a sequence already running
        seq_r <= DDL_LOAD;
        cnt_r <= 3'h1;
      end
      else if (cnt_r == DDL_CH_RIGHT)
      begin
        seq_r <= DDL_IDLE;
        cnt_r <= '0;
      end
      else
        cnt_r <= cnt_r + 3'h1;
    end
  end

  // Channel latches: one code per active edge of a load sequence
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DDL_NUM_CH; i++)
        latch_r[i] <= '0;
    end
    else if (load_en)
      latch_r[load_ch] <= pins_prev_r.code;
  end

  // ----------------------------------------------------------------
  // Output transfer
  // ----------------------------------------------------------------
  // Detect on a rising edge only, act on the following rising edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      xfer_seen_r <= 1'b0;
    else if (pix_rise)
      xfer_seen_r <= pins_prev_r.xfer;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DDL_NUM_CH; i++)
        out_r[i] <= '0;
    end
    else if (pix_rise && xfer_seen_r)
    begin
      for (int i = 0; i < DDL_NUM_CH; i++)
        out_r[i] <= latch_r[i];
    end
  end

  // Fresh mask shows which latches hold codes not yet transferred;
  // a load in the transfer cycle keeps its bit set.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fresh_r <= '0;
    else
    begin
      for (int i = 0; i < DDL_NUM_CH; i++)
      begin
        if (load_en && load_ch == DDL_PTR_W'(i))
          fresh_r[i] <= 1'b1;
        else if (pix_rise && xfer_seen_r)
          fresh_r[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Column conversion
  // ----------------------------------------------------------------
  for (genvar g = 0; g < DDL_NUM_CH; g++)
  begin : g_col
    ddl_col_conv u_conv (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pol_inv_i(ctrl_r.pol_inv),
      .lp_hold_i(ctrl_r.lp_hold),
      .code_i(out_r[g]),
      .level_o(column_voltage_outputs_o[g]),
      .above_mid_o(column_above_mid_o[g])
    );
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      column_bias_en_o <= 1'b0;
    else
      column_bias_en_o <= ~ctrl_r.lp_hold;
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= ddl_ctrl_t'(DDL_CTRL_RST);
    else if (wb_req && wb_we_i && wb_sel_i[0]
             && wb_adr_i == DDL_OFS_CTRL)
      ctrl_r <= ddl_ctrl_t'(wb_dat_i[DDL_CTRL_HOLD_BIT:0]);
  end

  always_comb
  begin
    status_word = '0;
    status_word[DDL_STAT_FRESH_LSB +: DDL_NUM_CH] = fresh_r;
    status_word[DDL_STAT_LOAD_BIT] = (seq_r == DDL_LOAD);
    status_word[DDL_STAT_START_BIT] = start_armed_r;
    status_word[DDL_STAT_XFER_BIT] = xfer_seen_r;
    status_word[DDL_STAT_PTR_LSB +: DDL_PTR_W] = ptr_r;
  end

  always_comb
  begin
    rd_data = '0;
    if (wb_adr_i == DDL_OFS_CTRL)
      rd_data[DDL_CTRL_HOLD_BIT:0] = ctrl_r;
    else if (wb_adr_i == DDL_OFS_STATUS)
      rd_data = status_word;
    for (int i = 0; i < DDL_NUM_CH; i++)
    begin
      if (wb_adr_i == DDL_OFS_LATCH0 + DDL_ADR_W'(4 * i))
        rd_data[DDL_CODE_W-1:0] = latch_r[i];
      if (wb_adr_i == DDL_OFS_OUT0 + DDL_ADR_W'(4 * i))
        rd_data[DDL_CODE_W-1:0] = out_r[i];
    end
  end

  // Unmapped addresses still acknowledge and read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (wb_req && !wb_we_i)
      wb_dat_o <= rd_data;
  end

endmodule

// ==== tb/ddl_loader_properties.sv ====
// Purpose: port-level checks of the column loader
// Assumes: bus master holds each request until ack
// Notes: bound to every ddl_loader instance
module ddl_loader_properties
  import ddl_pkg::*;
(
  // System and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DDL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and columns
  input wire logic pixel_clock_i,
  input wire logic [DDL_NUM_CH-1:0][DDL_CODE_W-1:0] column_voltage_outputs_o,
  input wire logic [DDL_NUM_CH-1:0] column_above_mid_o,
  input wire logic column_bias_en_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ctrl_wr;
    wb_ack_o && wb_we_i && wb_adr_i == DDL_OFS_CTRL && wb_sel_i[0];
  endsequence
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_idle;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack unasked");
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'hfc |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not 0");
  property p_rst_zero;
    $fell(rst_i) |-> column_voltage_outputs_o == '0 && !column_above_mid_o;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset outs");
  // Hold edges move outputs too, so they are masked out here
  property p_xfer_rise;
    $changed(column_voltage_outputs_o) && column_bias_en_o &&
      $past(column_bias_en_o) && $past(column_bias_en_o, 2)
      |-> $past(pixel_clock_i, 2);
  endproperty
  a_xfer_rise: assert property (p_xfer_rise) else $error("xfer edge");
  property p_hold_bias;
    s_ctrl_wr |-> ##2
      column_bias_en_o == !$past(wb_dat_i[DDL_CTRL_HOLD_BIT], 2);
  endproperty
  a_hold_bias: assert property (p_hold_bias) else $error("bias");
  property p_hold_zero;
    !column_bias_en_o && !$past(column_bias_en_o)
      |-> column_voltage_outputs_o == '0 && !column_above_mid_o;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("hold");
  property p_pol;
    s_ctrl_wr ##0 !wb_dat_i[DDL_CTRL_HOLD_BIT] |-> ##2 column_above_mid_o
      == {DDL_NUM_CH{$past(wb_dat_i[DDL_CTRL_POL_BIT], 2)}};
  endproperty
  a_pol: assert property (p_pol) else $error("polarity");
endmodule

bind ddl_loader ddl_loader_properties ddl_loader_properties_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pixel_clock_i(pixel_clock_i),
  .column_voltage_outputs_o(column_voltage_outputs_o),
  .column_above_mid_o(column_above_mid_o),
  .column_bias_en_o(column_bias_en_o)
);

// ==== tb/ddl_tctl_model.sv ====
// Purpose: timing controller that feeds the column loader
// Assumes: called just after a rising system clock edge
// Notes: a beat is 10 clocks, pixel clock 4 high and idle low
module ddl_tctl_model
  import ddl_pkg::*;
(
  // System
  input wire logic clk_i,
  // Pins
  output logic pixel_clock_o = 1'b0,
  output logic [DDL_CODE_W-1:0] code_o = 10'h2aa,
  output logic start_o = 1'b0,
  output logic xfer_o = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Beats
  // ----------------------------------------------------------------
  // Pins move 2 clocks after the fall so no edge coincides with them
  task automatic beat(input logic [DDL_CODE_W-1:0] c, input logic s,
                      input logic x);
    code_o <= c;
    start_o <= s;
    xfer_o <= x;
    repeat (4) @(posedge clk_i);
    pixel_clock_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    pixel_clock_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic frame(input logic [5:0][DDL_CODE_W-1:0] c, input logic x);
    beat(~c[0], 1'b1, 1'b0);
    for (int j = 0; j < 6; j++)
      beat(c[j], 1'b0, 1'b0);
    if (x)
    begin
      beat(~c[5], 1'b0, 1'b1);
      beat(c[5], 1'b0, 1'b0);
    end
    code_o <= ~code_o;
  endtask
endmodule

// ==== tb/ddl_loader_tb.sv ====
// Purpose: self-checking bench of the column loader
// Assumes: loader answers every bus request with ack
// Notes: one frame for each mix of direction and polarity, rising edge with normal polarity, falling with inverted
module ddl_loader_tb
  import ddl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [5:0][9:0] CODES =
    {10'h3ff, 10'h000, 10'h155, 10'h2aa, 10'h001, 10'h3fe};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, pclk;
  logic start, xfer, bias;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, q;
  logic [DDL_CODE_W-1:0] code;
  logic [DDL_NUM_CH-1:0][DDL_CODE_W-1:0] outs;
  logic [DDL_NUM_CH-1:0] above;
  logic [5:0][9:0] c;
  int n_errors = 0, checks_done = 0, cycles = 0;
  always #12.5 clk_i = ~clk_i;
  ddl_loader ddl_loader_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pixel_clock_i(pclk),
    .pixel_code_input_i(code), .sequence_start_strobe_i(start),
    .output_transfer_strobe_i(xfer), .column_voltage_outputs_o(outs),
    .column_above_mid_o(above), .column_bias_en_o(bias));
  ddl_tctl_model ddl_tctl_model_inst (.clk_i(clk_i), .pixel_clock_o(pclk),
    .code_o(code), .start_o(start), .xfer_o(xfer));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    do @(posedge clk_i); while (wb_ack !== 1'b1 && n++ < 40);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk("ack", 32'h1, 32'(wb_ack));
  endtask
  task automatic chk_outs(input logic d, input logic p);
    for (int i = 0; i < DDL_NUM_CH; i++)
      chk("column", 32'(DDL_FULL_SCALE - c[d ? 5 - i : i]),
          32'(outs[i]));
    chk("above_mid", 32'({6{p}}), 32'(above));
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("bias", 32'h1, 32'(bias));
    c = '0;
    chk_outs(1'b0, 1'b0);
    wb(1'b0, DDL_OFS_CTRL, 32'h0, 4'hf);
    chk("ctrl", 32'(DDL_CTRL_RST), q);
    wb(1'b0, 8'hfc, 32'h0, 4'hf);
    chk("unmapped", 32'h0, q);
    for (int m = 0; m < 4; m++)
    begin
      for (int j = 0; j < 6; j++)
        c[j] = CODES[(j + m) % 6];
      wb(1'b1, DDL_OFS_CTRL, 32'({m[0], m[1], ~m[0]}), 4'hf);
      ddl_tctl_model_inst.frame(c, 1'b1);
      chk_outs(m[1], m[0]);
    end
    wb(1'b0, DDL_OFS_LATCH0 + 8'h14, 32'h0, 4'hf);
    chk("latch5", 32'(c[0]), q);
    // Loaded but not transferred: columns keep the previous set
    ddl_tctl_model_inst.frame(~c, 1'b0);
    chk_outs(1'b1, 1'b1);
    wb(1'b0, DDL_OFS_STATUS, 32'h0, 4'hf);
    chk("fresh", 32'h3f, q & 32'h3f);
    chk("loading", 32'h0, 32'(q[DDL_STAT_LOAD_BIT]));
    c = ~c;
    ddl_tctl_model_inst.beat(c[5], 1'b0, 1'b1);
    ddl_tctl_model_inst.beat(~c[5], 1'b0, 1'b0);
    chk_outs(1'b1, 1'b1);
    wb(1'b1, DDL_OFS_CTRL, 32'hf, 4'hf);
    repeat (3) @(posedge clk_i);
    chk("bias_hold", 32'h0, 32'(bias));
    chk("column_hold", 32'h0, 32'(|outs));
    wb(1'b1, DDL_OFS_CTRL, 32'h0, 4'h0);
    wb(1'b0, DDL_OFS_CTRL, 32'h0, 4'hf);
    chk("ctrl_sel", 32'hf, q);
    wb(1'b1, DDL_OFS_CTRL, 32'h5, 4'hf);
    repeat (3) @(posedge clk_i);
    chk_outs(1'b1, 1'b1);
    wb(1'b0, DDL_OFS_OUT0, 32'h0, 4'hf);
    chk("out0", 32'(c[5]), q);
    give_verdict();
  end
endmodule
